// *** src/jesd_transport_mode_mapper.sv ***
// Summary of operation
// - only modes 0..15 exist; every transport parameter except K in 8b10b modes comes from the mode
// - in 8b10b modes K in frames is frames_per_multiframe_minus_one plus one; values outside mode limits set km1_err
// - mode 0: 12-bit, 8b10b, 8 lanes, M8 F8 S5, K 4:4:256, R 8
// - mode 1: 12-bit, 8b10b, 6 lanes, M4 F2 S2 HD1, K 16 step, R 10
// - mode 2: 8-bit, 8b10b, 4 lanes, M4 F1 S1, K 32 step, R 10
// - mode 3: 10-bit, 8b10b, 4 lanes, M4 F5 S4, R 12.5, reduced clock
// - mode 4: 12-bit, 64b66b, 3 lanes, M4 F2 S1 HD1 E1, K 128, R 16.5
// - mode 5: 8-bit, 64b66b, 2 lanes, M4 F2 S1 E1, K 128, R 16.5
// - mode 6: 12-bit, 64b66b, 6 lanes, M4 F2 S2 HD1 E1, K 128, R 8.25
// - mode 7: 8-bit, 64b66b, 4 lanes, M4 F1 S1 E1, K 256, R 8.25
// - mode 8: 12-bit, 64b66b, 4 lanes, M4 F3 S2 E3, K 256, R 12.375
// - mode 9: 8-bit, 8b10b, 8 lanes, M4 F1 S2, K 32 step, R 5
// - mode 10: 10-bit, 8b10b, 8 lanes, M8 F5 S4, K 32 step, R 6.25
// - mode 11: two-channel 12-bit, 8b10b, 8 lanes, M8 F8 S5, R 4
// - mode 12: two-channel 8-bit, 8b10b, 8 lanes, M2 F1 S4, R 2.5
// - mode 13: two-channel 10-bit, 8b10b, 8 lanes, M8 F5 S4, R 3.125
// - mode 14: 12-bit, 64b66b, 8 lanes, M8 F3 S2 E3, K 256, R 6.1875
// - mode 15: two-channel 12-bit, 64b66b, 8 lanes, HD2 E3, K 256, R 3.09375
// - 64b66b multiframe length fixed at 8*32*E/F, not programmable
// - lowest lanes used, rest powered down; lane id equals lane index
// - tail bits zero; only modes 0 and 1 place samples, most significant bit first; lane data stays zero in other modes
// - alignment checksum is sum of parameter fields modulo 256
// - alignment sequence only in 8b10b modes
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

module jesd_transport_mode_mapper #(
	parameter int SAMPLE_BITS = 12,
	parameter int FRAME_SAMPLES = 10
) (
	input  wire logic                                 I_REF_CLK,
	input  wire logic                                 I_RST_B,
	input  wire logic                                 I_HSEL,
	input  wire logic [31:0]                          I_HADDR,
	input  wire logic [1:0]                           I_HTRANS,
	input  wire logic                                 I_HWRITE,
	input  wire logic [2:0]                           I_HSIZE,
	input  wire logic [31:0]                          I_HWDATA,
	input  wire logic                                 I_HREADY,
	input  wire logic                                 I_SAMPLE_VALID,
	input  wire logic [4*FRAME_SAMPLES*SAMPLE_BITS-1:0] I_SAMPLES,
	output logic [31:0]                               O_HRDATA,
	output logic                                      O_HREADYOUT,
	output logic                                      O_HRESP,
	output logic [jesd_map_pkg::NUM_LANES*jesd_map_pkg::LANE_BITS-1:0] O_LANE_DATA,
	output logic                                      O_LANE_VALID,
	output logic [jesd_map_pkg::NUM_LANES-1:0]        O_LANE_ON,
	output logic                                      O_ILAS_EN,
	output logic [7:0]                                O_CHECKSUM,
	output logic [8:0]                                O_K_FRAMES
);

	// ----------------------------------------
	// registers and state
	// ----------------------------------------
	localparam int LB = jesd_map_pkg::LANE_BITS;
	localparam int SB = SAMPLE_BITS;

	logic [3:0]                    link_mode_select;
	logic [7:0]                    frames_per_multiframe_minus_one;
	logic [7:0]                    device_id;
	logic                          scrambler_en;
	logic                          wr_pend;
	logic                          rd_pend;
	logic [31:0]                   ph_addr;
	logic                          km1_err;
	jesd_map_pkg::mode_param_type  par;
	jesd_map_pkg::map_state_type   state;
	jesd_map_pkg::map_state_type   next_state;
	jesd_map_pkg::k_result_type    kres;
	jesd_map_pkg::link_status_type lstat;
	logic [jesd_map_pkg::NUM_LANES*LB-1:0] next_lanes;

	assign par = jesd_map_pkg::mode_table(link_mode_select);

	// ----------------------------------------
	// multiframe length
	// ----------------------------------------
	function automatic jesd_map_pkg::k_result_type k_calc(
		input jesd_map_pkg::mode_param_type p,
		input logic [7:0] km1
	);
		jesd_map_pkg::k_result_type r;
		logic [8:0] k;
		r = '0;
		k = {1'b0, km1} + 9'd1;
		if (p.enc_64b) begin
			// 8*32*E/F
			r.k_frames = 9'(jesd_map_pkg::FRAME_64B_NUM * int'(p.e_blocks) / int'(p.f_octets));
			r.km1_ok = 1'b1;
		end else begin
			r.k_frames = k;
			r.km1_ok = (k >= p.k_step) && ((k % p.k_step) == 9'd0);
		end
		return r;
	endfunction

	assign kres = k_calc(par, frames_per_multiframe_minus_one);

	// ----------------------------------------
	// lane enable, alignment checksum
	// ----------------------------------------
	function automatic logic [7:0] param_sum(
		input jesd_map_pkg::mode_param_type p,
		input logic [7:0] did,
		input logic [8:0] k,
		input logic scr,
		input int lid
	);
		logic [7:0] s;
		// fields stored as value minus one where the link does so
		s = did + 8'(lid) + 8'(p.lanes - 4'd1) + {7'd0, scr};
		s = s + 8'(p.f_octets - 4'd1) + 8'(k - 9'd1) + 8'(p.m_conv - 4'd1);
		s = s + 8'(p.n_bits - 5'd1) + 8'(p.n_bits - 5'd1);
		s = s + jesd_map_pkg::SUBCLASS_VAL + jesd_map_pkg::JESDV_VAL;
		s = s + 8'(p.s_samples - 3'd1);
		return s;
	endfunction

	always_comb begin
		lstat = '0;
		for (int i = 0; i < jesd_map_pkg::NUM_LANES; i++) begin
			lstat.lane_on[i] = (4'(i) < par.lanes);
		end
		lstat.checksum = param_sum(par, device_id, kres.k_frames, scrambler_en, 0);
		lstat.ilas_en = ~par.enc_64b;
	end

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			ph_addr <= '0;
		end else if (I_HREADY) begin
			wr_pend <= I_HSEL && I_HTRANS[1] && I_HWRITE;
			rd_pend <= I_HSEL && I_HTRANS[1] && !I_HWRITE;
			ph_addr <= I_HADDR;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			link_mode_select <= jesd_map_pkg::MODE_RESET;
			frames_per_multiframe_minus_one <= jesd_map_pkg::KM1_RESET;
			device_id <= jesd_map_pkg::DID_RESET;
			scrambler_en <= 1'b0;
		end else if (wr_pend) begin
			unique case (ph_addr[7:0])
				jesd_map_pkg::OFS_MODE[7:0]: link_mode_select <= I_HWDATA[3:0];
				jesd_map_pkg::OFS_KM1[7:0]: frames_per_multiframe_minus_one <= I_HWDATA[7:0];
				jesd_map_pkg::OFS_LINK[7:0]: begin
					device_id <= I_HWDATA[7:0];
					scrambler_en <= I_HWDATA[8];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_HRDATA <= '0;
		end else if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
			unique case (I_HADDR[7:0])
				jesd_map_pkg::OFS_MODE[7:0]: O_HRDATA <= {28'd0, link_mode_select};
				jesd_map_pkg::OFS_KM1[7:0]: O_HRDATA <= {24'd0, frames_per_multiframe_minus_one};
				jesd_map_pkg::OFS_PARAMS[7:0]: O_HRDATA <= {3'd0, par.enc_64b, par.two_ch,
					par.reduced_clk, par.n_bits, par.lanes, par.m_conv, par.f_octets,
					par.s_samples, par.hd, par.e_blocks, 2'd0};
				jesd_map_pkg::OFS_LINK[7:0]: O_HRDATA <= {23'd0, scrambler_en, device_id};
				jesd_map_pkg::OFS_STATUS[7:0]: O_HRDATA <= {km1_err, 6'd0, kres.k_frames,
					lstat.lane_on, lstat.checksum};
				default: O_HRDATA <= '0;
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_HREADYOUT <= 1'b1;
			O_HRESP <= 1'b0;
		end else begin
			O_HREADYOUT <= 1'b1;
			O_HRESP <= 1'b0;
		end
	end

	// ----------------------------------------
	// configuration outputs
	// ----------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_LANE_ON <= '0;
			O_ILAS_EN <= 1'b0;
			O_CHECKSUM <= '0;
			O_K_FRAMES <= '0;
			km1_err <= 1'b0;
		end else begin
			O_LANE_ON <= lstat.lane_on;
			O_ILAS_EN <= lstat.ilas_en;
			O_CHECKSUM <= lstat.checksum;
			O_K_FRAMES <= kres.k_frames;
			km1_err <= ~kres.km1_ok;
		end
	end

	// ----------------------------------------
	// frame state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			jesd_map_pkg::MAP_IDLE: next_state = jesd_map_pkg::MAP_LOAD;
			jesd_map_pkg::MAP_LOAD: next_state = jesd_map_pkg::MAP_RUN;
			jesd_map_pkg::MAP_RUN: next_state = jesd_map_pkg::MAP_RUN;
			default: next_state = jesd_map_pkg::MAP_IDLE;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			state <= jesd_map_pkg::MAP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// sample to lane packing
	// ----------------------------------------
	// sample n of channel c, low 12 bits of its SAMPLE_BITS-wide slot
	function automatic logic [11:0] smp(
		input logic [4*FRAME_SAMPLES*SAMPLE_BITS-1:0] s,
		input int c,
		input int n
	);
		return s[(c*FRAME_SAMPLES+n)*SB +: 12];
	endfunction

	always_comb begin
		next_lanes = '0;
		unique case (link_mode_select)
			4'h0: begin
				for (int c = 0; c < 4; c++) begin
					for (int j = 0; j < 5; j++) begin
						next_lanes[(2*c)*LB + LB-1-12*j -: 12] = smp(I_SAMPLES, c, 2*j);
						next_lanes[(2*c+1)*LB + LB-1-12*j -: 12] = smp(I_SAMPLES, c, 2*j+1);
					end
				end
			end
			4'h1: begin
				for (int g = 0; g < 2; g++) begin
					{next_lanes[(3*g)*LB + LB-1 -: 16], next_lanes[(3*g+1)*LB + LB-1 -: 16],
						next_lanes[(3*g+2)*LB + LB-1 -: 16]} =
						{smp(I_SAMPLES, 2*g, 0), smp(I_SAMPLES, 2*g, 1),
						smp(I_SAMPLES, 2*g+1, 0), smp(I_SAMPLES, 2*g+1, 1)};
				end
			end
			default: next_lanes = '0;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_LANE_DATA <= '0;
			O_LANE_VALID <= 1'b0;
		end else begin
			// unused lanes held at zero
			for (int l = 0; l < jesd_map_pkg::NUM_LANES; l++) begin
				O_LANE_DATA[l*LB +: LB] <= lstat.lane_on[l] ? next_lanes[l*LB +: LB] : '0;
			end
			O_LANE_VALID <= I_SAMPLE_VALID && (state == jesd_map_pkg::MAP_RUN)
				&& (link_mode_select <= 4'h1);
		end
	end

endmodule

`default_nettype wire

// *** src/jesd_map_pkg.sv ***
package jesd_map_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [31:0] OFS_MODE      = 32'h0000_0000;
	localparam logic [31:0] OFS_KM1       = 32'h0000_0004;
	localparam logic [31:0] OFS_PARAMS    = 32'h0000_0008;
	localparam logic [31:0] OFS_LINK      = 32'h0000_000C;
	localparam logic [31:0] OFS_STATUS    = 32'h0000_0010;

	localparam logic [3:0]  MODE_RESET    = 4'h0;
	localparam logic [7:0]  KM1_RESET     = 8'h1F;
	localparam logic [7:0]  DID_RESET     = 8'h00;
	localparam int          NUM_LANES     = 8;
	localparam int          LANE_BITS     = 64;
	localparam int          FRAME_64B_NUM = 256;
	localparam logic [7:0]  JESDV_VAL     = 8'h01;
	localparam logic [7:0]  SUBCLASS_VAL  = 8'h01;

	localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0]  HTRANS_SEQ    = 2'b11;

	// ----------------------------------------
	// per-mode transport parameters
	// ----------------------------------------
	typedef struct packed {
		logic       enc_64b;
		logic [4:0] n_bits;
		logic [3:0] lanes;
		logic [3:0] m_conv;
		logic [3:0] f_octets;
		logic [2:0] s_samples;
		logic [1:0] hd;
		logic [1:0] e_blocks;
		logic [8:0] k_step;
		logic [8:0] k_fixed;
		logic [15:0] r_x1024;
		logic       two_ch;
		logic       reduced_clk;
	} mode_param_type;

	typedef struct packed {
		logic [2:0] lanes_en_ignored;
		logic [8:0] k_frames;
		logic       km1_ok;
	} k_result_type;

	typedef struct packed {
		logic [7:0] lane_on;
		logic [7:0] checksum;
		logic       ilas_en;
	} link_status_type;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_req_type;

	typedef enum logic [2:0] {
		MAP_IDLE = 3'b001,
		MAP_LOAD = 3'b010,
		MAP_RUN  = 3'b100
	} map_state_type;

	function automatic mode_param_type mode_table(input logic [3:0] sel);
		mode_param_type p;
		p = '0;
		unique case (sel)
			4'h0: p = '{1'b0, 5'd12, 4'd8, 4'd8, 4'd8, 3'd5, 2'd0, 2'd0,
				9'd4, 9'd0, 16'd8192, 1'b0, 1'b0};
			4'h1: p = '{1'b0, 5'd12, 4'd6, 4'd4, 4'd2, 3'd2, 2'd1, 2'd0,
				9'd16, 9'd0, 16'd10240, 1'b0, 1'b0};
			4'h2: p = '{1'b0, 5'd8, 4'd4, 4'd4, 4'd1, 3'd1, 2'd0, 2'd0,
				9'd32, 9'd0, 16'd10240, 1'b0, 1'b0};
			4'h3: p = '{1'b0, 5'd10, 4'd4, 4'd4, 4'd5, 3'd4, 2'd0, 2'd0,
				9'd32, 9'd0, 16'd12800, 1'b0, 1'b1};
			4'h4: p = '{1'b1, 5'd12, 4'd3, 4'd4, 4'd2, 3'd1, 2'd1, 2'd1,
				9'd0, 9'd128, 16'd16896, 1'b0, 1'b1};
			4'h5: p = '{1'b1, 5'd8, 4'd2, 4'd4, 4'd2, 3'd1, 2'd0, 2'd1,
				9'd0, 9'd128, 16'd16896, 1'b0, 1'b1};
			4'h6: p = '{1'b1, 5'd12, 4'd6, 4'd4, 4'd2, 3'd2, 2'd1, 2'd1,
				9'd0, 9'd128, 16'd8448, 1'b0, 1'b0};
			4'h7: p = '{1'b1, 5'd8, 4'd4, 4'd4, 4'd1, 3'd1, 2'd0, 2'd1,
				9'd0, 9'd256, 16'd8448, 1'b0, 1'b0};
			4'h8: p = '{1'b1, 5'd12, 4'd4, 4'd4, 4'd3, 3'd2, 2'd0, 2'd3,
				9'd0, 9'd256, 16'd12672, 1'b0, 1'b1};
			4'h9: p = '{1'b0, 5'd8, 4'd8, 4'd4, 4'd1, 3'd2, 2'd0, 2'd0,
				9'd32, 9'd0, 16'd5120, 1'b0, 1'b0};
			4'hA: p = '{1'b0, 5'd10, 4'd8, 4'd8, 4'd5, 3'd4, 2'd0, 2'd0,
				9'd32, 9'd0, 16'd6400, 1'b0, 1'b0};
			4'hB: p = '{1'b0, 5'd12, 4'd8, 4'd8, 4'd8, 3'd5, 2'd0, 2'd0,
				9'd4, 9'd0, 16'd4096, 1'b1, 1'b0};
			4'hC: p = '{1'b0, 5'd8, 4'd8, 4'd2, 4'd1, 3'd4, 2'd0, 2'd0,
				9'd32, 9'd0, 16'd2560, 1'b1, 1'b0};
			4'hD: p = '{1'b0, 5'd10, 4'd8, 4'd8, 4'd5, 3'd4, 2'd0, 2'd0,
				9'd32, 9'd0, 16'd3200, 1'b1, 1'b0};
			4'hE: p = '{1'b1, 5'd12, 4'd8, 4'd8, 4'd3, 3'd2, 2'd0, 2'd3,
				9'd0, 9'd256, 16'd6336, 1'b0, 1'b0};
			4'hF: p = '{1'b1, 5'd12, 4'd8, 4'd8, 4'd3, 3'd2, 2'd2, 2'd3,
				9'd0, 9'd256, 16'd3168, 1'b1, 1'b0};
		endcase
		return p;
	endfunction

endpackage

// *** test/jesd_map_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none

module jesd_map_asserts #(
	parameter int SAMPLE_BITS   = 12,
	parameter int FRAME_SAMPLES = 10
) (
	input wire logic                                 I_REF_CLK,
	input wire logic                                 I_RST_B,
	input wire logic                                 I_SAMPLE_VALID,
	input wire logic [4*FRAME_SAMPLES*SAMPLE_BITS-1:0] I_SAMPLES,
	input wire logic                                 O_HREADYOUT,
	input wire logic                                 O_HRESP,
	input wire logic [511:0]                         O_LANE_DATA,
	input wire logic                                 O_LANE_VALID,
	input wire logic [7:0]                           O_LANE_ON,
	input wire logic                                 O_ILAS_EN,
	input wire logic [8:0]                           O_K_FRAMES
);
	logic [7:0] tail_or;

	always_comb begin
		tail_or = '0;
		for (int l = 0; l < 8; l++) begin
			tail_or[l] = |O_LANE_DATA[l*64 +: 4];
		end
	end

	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_B);

	// frame taken in mode 0, lanes out next cycle
	sequence full_frame_s;
		I_SAMPLE_VALID && O_LANE_ON == 8'hFF ##1 O_LANE_VALID;
	endsequence

	hready_high_a: assert property (O_HREADYOUT) else $error("hreadyout low");
	okay_resp_a: assert property (!O_HRESP) else $error("error response");
	frame_map_a: assert property (full_frame_s |->
		O_LANE_DATA[63 -: SAMPLE_BITS] == $past(I_SAMPLES[SAMPLE_BITS-1:0])
		&& O_LANE_DATA[127 -: SAMPLE_BITS] == $past(I_SAMPLES[2*SAMPLE_BITS-1:SAMPLE_BITS]))
		else $error("lane 0 or 1 first sample wrong");
	tail_zero_a: assert property (O_LANE_VALID && O_LANE_ON == 8'hFF |-> tail_or == 8'h00)
		else $error("tail bits not zero");
	valid_cause_a: assert property (O_LANE_VALID |-> $past(I_SAMPLE_VALID) && O_ILAS_EN)
		else $error("lane valid without frame");
	lanes_lowest_a: assert property ($past(I_RST_B) |-> O_LANE_ON != 8'h00
		&& ((O_LANE_ON + 8'h01) & O_LANE_ON) == 8'h00) else $error("lanes not lowest");
	k_range_a: assert property ($past(I_RST_B) |-> O_K_FRAMES inside {[9'h001:9'h100]})
		else $error("multiframe length out of range");
	k_fixed_a: assert property ($past(I_RST_B) && !O_ILAS_EN |->
		O_K_FRAMES inside {9'h080, 9'h100}) else $error("wide mode length not fixed");
endmodule

bind jesd_transport_mode_mapper jesd_map_asserts #(
	.SAMPLE_BITS  (SAMPLE_BITS),
	.FRAME_SAMPLES(FRAME_SAMPLES)
) u_jesd_map_asserts (
	.I_REF_CLK     (I_REF_CLK),
	.I_RST_B       (I_RST_B),
	.I_SAMPLE_VALID(I_SAMPLE_VALID),
	.I_SAMPLES     (I_SAMPLES),
	.O_HREADYOUT   (O_HREADYOUT),
	.O_HRESP       (O_HRESP),
	.O_LANE_DATA   (O_LANE_DATA),
	.O_LANE_VALID  (O_LANE_VALID),
	.O_LANE_ON     (O_LANE_ON),
	.O_ILAS_EN     (O_ILAS_EN),
	.O_K_FRAMES    (O_K_FRAMES)
);

`default_nettype wire

// *** test/jesd_rx_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// rebuilds the per-channel samples of modes 0 and 1 from the lowest lanes
module jesd_rx_model (
	input  wire logic [3:0]   i_mode,
	input  wire logic [511:0] i_lane_data,
	input  wire logic         i_lane_valid,
	output logic      [480:0] o_frame,
	output logic              o_valid
);
	logic [47:0] w;

	always_comb begin
		o_frame = '0;
		w = '0;
		o_valid = i_lane_valid;
		for (int c = 0; c < 4; c++) begin
			if (i_mode == 4'h0) begin
				for (int n = 0; n < 10; n++) begin
					o_frame[(c*10+n)*12 +: 12] = i_lane_data[(2*c+n%2)*64+52-12*(n/2) +: 12];
				end
				o_frame[480] = o_frame[480] | (|i_lane_data[c*128 +: 4])
					| (|i_lane_data[c*128+64 +: 4]);
			end
		end
		for (int g = 0; g < 2; g++) begin
			w = {i_lane_data[g*192+48 +: 16], i_lane_data[g*192+112 +: 16],
				i_lane_data[g*192+176 +: 16]};
			if (i_mode == 4'h1) begin
				o_frame[g*240 +: 24] = {w[35:24], w[47:36]};
				o_frame[g*240+120 +: 24] = {w[11:0], w[23:12]};
			end
		end
	end
endmodule

`default_nettype wire

// *** test/test_jesd_transport_mode_mapper.sv ***
`timescale 1ns/100ps
`default_nettype none

module test_jesd_transport_mode_mapper;
	logic                      ref_clk;
	logic                      rst_b;
	jesd_map_pkg::ahb_req_type bus;
	logic                      sample_valid;
	logic [479:0]              samples;
	logic [31:0]               hrdata;
	logic                      hreadyout;
	logic [511:0]              lane_data;
	logic                      lane_valid;
	logic [7:0]                lane_on;
	logic                      ilas_en;
	logic [7:0]                checksum;
	logic [8:0]                k_frames;
	logic [480:0]              rx_frame;
	logic                      rx_valid;
	logic [3:0]                cur_mode;
	logic [480:0]              exp_q[$];
	logic [31:0]               rd;
	logic [31:0]               did;
	logic [8:0]                k;
	logic [7:0]                mask;
	logic [31:0]               par_exp;
	logic [23:0]               fld;
	logic [15:0]               two_ch_of = 16'hB800;
	logic [15:0]               slow_clk_of = 16'h0138;
	// per mode: N, M, F, S, HD, E one nibble each
	logic [23:0]               fld_of[16] = '{24'hC8_8500, 24'hC4_2210, 24'h84_1100, 24'hA4_5400,
		24'hC4_2111, 24'h84_2101, 24'hC4_2211, 24'h84_1101, 24'hC4_3203, 24'h84_1200,
		24'hA8_5400, 24'hC8_8500, 24'h82_1400, 24'hA8_5400, 24'hC8_3203, 24'hC8_3223};
	int                        mismatches;
	int                        tests_run;
	int                        cycles;
	int                        seed;
	int                        lanes_of[16] = '{8, 6, 4, 4, 3, 2, 6, 4, 4, 8, 8, 8, 8, 8, 8, 8};
	int                        kfix_of[16] = '{0, 0, 0, 0, 128, 128, 128, 256, 256, 0, 0, 0, 0, 0,
		256, 256};

	jesd_transport_mode_mapper u_jesd_transport_mode_mapper (
		.I_REF_CLK     (ref_clk),
		.I_RST_B       (rst_b),
		.I_HSEL        (bus.hsel),
		.I_HADDR       (bus.haddr),
		.I_HTRANS      (bus.htrans),
		.I_HWRITE      (bus.hwrite),
		.I_HSIZE       (bus.hsize),
		.I_HWDATA      (bus.hwdata),
		.I_HREADY      (hreadyout),
		.I_SAMPLE_VALID(sample_valid),
		.I_SAMPLES     (samples),
		.O_HRDATA      (hrdata),
		.O_HREADYOUT   (hreadyout),
		.O_HRESP       (),
		.O_LANE_DATA   (lane_data),
		.O_LANE_VALID  (lane_valid),
		.O_LANE_ON     (lane_on),
		.O_ILAS_EN     (ilas_en),
		.O_CHECKSUM    (checksum),
		.O_K_FRAMES    (k_frames)
	);

	jesd_rx_model u_jesd_rx_model (
		.i_mode      (cur_mode),
		.i_lane_data (lane_data),
		.i_lane_valid(lane_valid),
		.o_frame     (rx_frame),
		.o_valid     (rx_valid)
	);

	always #2.5 ref_clk = ~ref_clk;

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_frame(input logic [480:0] got, input logic [480:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("counts: tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus.hsel <= 1'b1;
		bus.haddr <= a;
		bus.htrans <= jesd_map_pkg::HTRANS_NONSEQ;
		bus.hwrite <= wr;
		bus.hsize <= 3'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		bus.htrans <= 2'h0;
		bus.hsel <= 1'b0;
		bus.hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// random frames; only modes 0 and 1 produce lane data
	task automatic send(input int n);
		logic [479:0] s;
		logic [480:0] e;
		for (int i = 0; i < n; i++) begin
			for (int w = 0; w < 15; w++) s[w*32 +: 32] = $random(seed);
			e = {1'b0, s};
			for (int j = 0; j < 40; j++) if (cur_mode == 4'h1 && j % 10 > 1) e[j*12 +: 12] = '0;
			if (cur_mode < 4'h2) exp_q.push_back(e);
			@(posedge ref_clk);
			samples <= s;
			sample_valid <= 1'b1;
		end
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	always @(posedge ref_clk) begin
		if (rx_valid === 1'b1) begin
			chk_frame(rx_frame, exp_q.size() ? exp_q.pop_front() : {481{1'bx}});
		end
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end

	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		bus = '0;
		sample_valid = 1'b0;
		samples = '0;
		cur_mode = 4'h0;
		seed = 32'h531f_2014;
		mismatches = 0;
		tests_run = 0;
		cycles = 0;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		ahb(1'b0, jesd_map_pkg::OFS_MODE, 32'h0);
		chk_word(rd, 32'h0000_0000);
		ahb(1'b0, jesd_map_pkg::OFS_KM1, 32'h0);
		chk_word(rd, 32'h0000_001F);
		ahb(1'b0, jesd_map_pkg::OFS_STATUS, 32'h0);
		chk_word(rd, 32'h0020_FF50);
		did = $random(seed) & 32'h0000_01FF;
		ahb(1'b1, jesd_map_pkg::OFS_LINK, did);
		ahb(1'b0, jesd_map_pkg::OFS_STATUS, 32'h0);
		chk_word({16'h0000, rd[7:0], checksum},
			{16'h0000, {2{8'h50 + did[7:0] + {7'h00, did[8]}}}});
		ahb(1'b1, jesd_map_pkg::OFS_KM1, 32'h0000_003F);
		for (int m = 0; m < 16; m++) begin
			k = kfix_of[m] == 0 ? 9'h040 : 9'(kfix_of[m]);
			mask = 8'hFF >> (8 - lanes_of[m]);
			ahb(1'b1, jesd_map_pkg::OFS_MODE, 32'(m));
			ahb(1'b0, jesd_map_pkg::OFS_STATUS, 32'h0);
			chk_word(rd & 32'h01FF_FF00, {7'h00, k, mask, 8'h00});
			chk_word({14'h0, ilas_en, k_frames, lane_on}, {14'h0, kfix_of[m] == 0, k, mask});
			fld = fld_of[m];
			par_exp = {3'h0, kfix_of[m] != 0, two_ch_of[m], slow_clk_of[m], 1'b0, fld[23:20],
				4'(lanes_of[m]), fld[19:12], fld[10:8], fld[5:4], fld[1:0], 2'h0};
			ahb(1'b0, jesd_map_pkg::OFS_PARAMS, 32'h0);
			chk_word(rd, par_exp);
		end
		ahb(1'b1, jesd_map_pkg::OFS_MODE, 32'h0000_0001);
		ahb(1'b1, jesd_map_pkg::OFS_KM1, 32'h0000_0013);
		ahb(1'b0, jesd_map_pkg::OFS_STATUS, 32'h0);
		chk_word(rd & 32'h81FF_0000, 32'h8014_0000);
		ahb(1'b1, 32'h0000_0040, 32'hFFFF_FFFF);
		ahb(1'b0, 32'h0000_0040, 32'h0);
		chk_word(rd, 32'h0000_0000);
		ahb(1'b0, jesd_map_pkg::OFS_MODE, 32'h0);
		chk_word(rd, 32'h0000_0001);
		ahb(1'b1, jesd_map_pkg::OFS_MODE, 32'h0000_0000);
		cur_mode = 4'h0;
		send(12);
		ahb(1'b1, jesd_map_pkg::OFS_MODE, 32'h0000_0001);
		cur_mode = 4'h1;
		send(8);
		ahb(1'b1, jesd_map_pkg::OFS_MODE, 32'h0000_0005);
		cur_mode = 4'h5;
		send(4);
		chk_word(32'(exp_q.size()), 32'h0000_0000);
		report_and_stop();
	end
endmodule

`default_nettype wire
